// File: design/pes_pkg.sv
package pes_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int LATCH_W = 14;
	localparam int CMD_W = 22;
	localparam int MSG_W = 4;
	localparam int ID_W = 12;
	localparam int V1_CTRL_W = 8;

	// Register word addresses on the management port.
	localparam logic [ADDR_W-1:0] OFS_LATCH  = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_ENABLE = 5'h05;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h06;
	localparam logic [ADDR_W-1:0] OFS_HEADER = 5'h07;

	// Latched event bit positions, shared by the latch and enable registers.
	localparam int BIT_TIME_ADJUST    = 0;
	localparam int BIT_GEN_A_EVENT    = 1;
	localparam int BIT_GEN_A_SEQUENCE = 2;
	localparam int BIT_GEN_A_LEFTFULL = 3;
	localparam int BIT_GEN_B_EVENT    = 4;
	localparam int BIT_GEN_B_SEQUENCE = 5;
	localparam int BIT_GEN_B_LEFTFULL = 6;
	localparam int BIT_FIFO_A_NONEMPTY = 8;
	localparam int BIT_FIFO_A_OVERFLOW = 9;
	localparam int BIT_FIFO_B_NONEMPTY = 10;
	localparam int BIT_FIFO_B_OVERFLOW = 11;
	localparam int BIT_FIFO_C_NONEMPTY = 12;
	localparam int BIT_FIFO_C_OVERFLOW = 13;
	localparam int BIT_SUMMARY         = 14;

	// Live status register bit positions.
	localparam int SR_OVERWRITE_ERR = 0;
	localparam int SR_GEN_A_FULL    = 3;
	localparam int SR_GEN_B_FULL    = 6;
	localparam int SR_FIFO_A_NONEMPTY = 7;
	localparam int SR_FIFO_B_NONEMPTY = 8;
	localparam int SR_FIFO_C_NONEMPTY = 9;

	// Header register field position.
	localparam int HDR_MSG_LSB = 12;

	// Generator command word bit that asks for status latching.
	localparam int CMD_LATCH_BIT = 21;

	localparam logic [DATA_W-1:0] ENABLE_WRITE_MASK = 16'h3f7f;
	localparam logic [DATA_W-1:0] ENABLE_RESET      = 16'h0000;
	localparam logic [DATA_W-1:0] HEADER_RESET      = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_ZERO         = 16'h0000;

	function automatic logic pes_rise(input logic prev, input logic cur);
		return cur & ~prev;
	endfunction : pes_rise

	function automatic logic pes_fall(input logic prev, input logic cur);
		return prev & ~cur;
	endfunction : pes_fall

endpackage : pes_pkg

// File: design/pes_latch_bank.sv
`timescale 1ns/1ns
`default_nettype none
// Bits latched high by an event pulse, cleared as a group when the host reads them.
module pes_latch_bank
	import pes_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rstSync_b,
	input  wire logic [W-1:0] setPulse,
	input  wire logic         clearRead,
	output logic      [W-1:0] latched
);

	logic [W-1:0] next_latched;

	// A set arriving with the clearing read survives so the event is not lost.
	always_comb begin
		next_latched = (latched & ~{W{clearRead}}) | setPulse;
	end

	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			latched <= '0;
		end else begin
			latched <= next_latched;
		end
	end

endmodule : pes_latch_bank
`default_nettype wire

// File: design/pes_header_capture.sv
`timescale 1ns/1ns
`default_nettype none
module pes_header_capture
	import pes_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 rstSync_b,
	input  wire logic                 stampTransfer,
	input  wire logic                 stampIsPacket,
	input  wire logic                 stampIsVersion2,
	input  wire logic [V1_CTRL_W-1:0] stampV1Control,
	input  wire logic [MSG_W-1:0]     stampV2MessageType,
	input  wire logic [ID_W-1:0]      stampIdentity,
	output logic      [DATA_W-1:0]    headerInfo
);

	logic [DATA_W-1:0] next_headerInfo;
	logic [MSG_W-1:0]  messageTypeField;

	always_comb begin
		messageTypeField = stampIsVersion2 ? stampV2MessageType
		                                   : stampV1Control[MSG_W-1:0];
		next_headerInfo = headerInfo;
		// Edge timestamps leave the last packet header in place; software ignores it then.
		if (stampTransfer && stampIsPacket) begin
			next_headerInfo[HDR_MSG_LSB +: MSG_W] = messageTypeField;
			next_headerInfo[ID_W-1:0] = stampIdentity;
		end
	end

	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			headerInfo <= HEADER_RESET;
		end else begin
			headerInfo <= next_headerInfo;
		end
	end

endmodule : pes_header_capture
`default_nettype wire

// File: design/pes_event_status_regs.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - generator A sequence done latches bit 2
// - marked generator A event latches bit 1
// - time adjustment done latches bit 0
// - latched bits read once, then clear
// - enable bit gates its latched bit
// - enables at 13:8 and 6:0 writable
// - live FIFO not-empty flags at 9:7
// - live generator FIFO full at 6, 3
// - multicast overwrite error latched at bit 0
// - packet transfer loads message type 15:12
// - type from v1 control or v2 field
// - packet transfer loads identity at 11:0
// - summary bit 14 when enabled bit latched
// - FIFO overflow and not-empty events latched 13:8
module pes_event_status_regs
	import pes_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 rst_b,
	input  wire logic [ADDR_W-1:0]    regAddr,
	input  wire logic                 regRead,
	input  wire logic                 regWrite,
	input  wire logic [DATA_W-1:0]    regWdata,
	output logic      [DATA_W-1:0]    regRdata,
	input  wire logic                 timeAdjustDone,
	input  wire logic                 genASequenceDone,
	input  wire logic                 genAEventDone,
	input  wire logic [CMD_W-1:0]     genAEventCommand,
	input  wire logic                 genAFifoFull,
	input  wire logic                 genBSequenceDone,
	input  wire logic                 genBEventDone,
	input  wire logic [CMD_W-1:0]     genBEventCommand,
	input  wire logic                 genBFifoFull,
	input  wire logic                 stampFifoANonempty,
	input  wire logic                 stampFifoAOverflow,
	input  wire logic                 stampFifoBNonempty,
	input  wire logic                 stampFifoBOverflow,
	input  wire logic                 stampFifoCNonempty,
	input  wire logic                 stampFifoCOverflow,
	input  wire logic                 multicastOverwriteError,
	input  wire logic                 stampTransfer,
	input  wire logic                 stampIsPacket,
	input  wire logic                 stampIsVersion2,
	input  wire logic [V1_CTRL_W-1:0] stampV1Control,
	input  wire logic [MSG_W-1:0]     stampV2MessageType,
	input  wire logic [ID_W-1:0]      stampIdentity,
	output logic                      eventInterrupt
);

	logic               rstMeta_b;
	logic               rstSync_b;
	logic               next_rstMeta_b;
	logic               next_rstSync_b;
	logic [LATCH_W-1:0] latchSet;
	logic [LATCH_W-1:0] latchedEvents;
	logic [0:0]         overwriteLatched;
	logic [DATA_W-1:0]  eventInterruptEnable;
	logic [DATA_W-1:0] next_eventInterruptEnable;
	logic [DATA_W-1:0]  headerInfo;
	logic [DATA_W-1:0]  latchWord;
	logic [DATA_W-1:0]  statusWord;
	logic [DATA_W-1:0] next_regRdata;
	logic               prevGenAFull;
	logic               prevGenBFull;
	logic               prevFifoANonempty;
	logic               prevFifoBNonempty;
	logic               prevFifoCNonempty;
	logic               next_prevGenAFull;
	logic               next_prevGenBFull;
	logic               next_prevFifoANonempty;
	logic               next_prevFifoBNonempty;
	logic               next_prevFifoCNonempty;
	logic               readLatch;
	logic               readStatus;
	logic               summary;
	logic               next_eventInterrupt;

	// One decode serves the clear-on-read and enable-write strobes so the register addresses cannot drift apart.
	function automatic logic regHit(input logic strobe, input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] offset);
		return strobe && (addr == offset);
	endfunction : regHit

	// Reset is asserted at once but released only after two clean edges.
	// Only the second stage feeds the rest of the block, so a release that lands
	// close to an edge never reaches the state registers half-settled.
	always_comb begin
		next_rstMeta_b = 1'b1;
		next_rstSync_b = rstMeta_b;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_b <= 1'b0;
			rstSync_b <= 1'b0;
		end else begin
			rstMeta_b <= next_rstMeta_b;
			rstSync_b <= next_rstSync_b;
		end
	end

	// Previous samples of the live flags, used to find their transitions.
	// They clear in reset, so a FIFO already occupied at release reports once;
	// that costs one extra event but never hides a real one.
	always_comb begin
		next_prevGenAFull = genAFifoFull;
		next_prevGenBFull = genBFifoFull;
		next_prevFifoANonempty = stampFifoANonempty;
		next_prevFifoBNonempty = stampFifoBNonempty;
		next_prevFifoCNonempty = stampFifoCNonempty;
	end

	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			prevGenAFull <= 1'b0;
			prevGenBFull <= 1'b0;
			prevFifoANonempty <= 1'b0;
			prevFifoBNonempty <= 1'b0;
			prevFifoCNonempty <= 1'b0;
		end else begin
			prevGenAFull <= next_prevGenAFull;
			prevGenBFull <= next_prevGenBFull;
			prevFifoANonempty <= next_prevFifoANonempty;
			prevFifoBNonempty <= next_prevFifoBNonempty;
			prevFifoCNonempty <= next_prevFifoCNonempty;
		end
	end

	// Every bit of the set vector is a one-cycle request; the latch bank keeps it.
	always_comb begin
		latchSet = '0;

		// A finished time adjustment is reported once per completion.
		latchSet[BIT_TIME_ADJUST] = timeAdjustDone;

		// An event completion only counts when its command word asked for latching,
		// so unmarked events pass silently. Left-full is the falling edge of the
		// live full flag, seen against the sample of the cycle before.
		latchSet[BIT_GEN_A_EVENT] = genAEventDone & genAEventCommand[CMD_LATCH_BIT];
		latchSet[BIT_GEN_A_SEQUENCE] = genASequenceDone;
		latchSet[BIT_GEN_A_LEFTFULL] = pes_fall(prevGenAFull, genAFifoFull);

		// The second generator follows the same pattern on its own bits.
		latchSet[BIT_GEN_B_EVENT] = genBEventDone & genBEventCommand[CMD_LATCH_BIT];
		latchSet[BIT_GEN_B_SEQUENCE] = genBSequenceDone;
		latchSet[BIT_GEN_B_LEFTFULL] = pes_fall(prevGenBFull, genBFifoFull);

		// Not-empty is an edge, not a level: a FIFO that stays occupied reports
		// once, so software must drain it before it can be told again.
		latchSet[BIT_FIFO_A_NONEMPTY] = pes_rise(prevFifoANonempty, stampFifoANonempty);
		latchSet[BIT_FIFO_A_OVERFLOW] = stampFifoAOverflow;
		latchSet[BIT_FIFO_B_NONEMPTY] = pes_rise(prevFifoBNonempty, stampFifoBNonempty);
		latchSet[BIT_FIFO_B_OVERFLOW] = stampFifoBOverflow;
		latchSet[BIT_FIFO_C_NONEMPTY] = pes_rise(prevFifoCNonempty, stampFifoCNonempty);
		latchSet[BIT_FIFO_C_OVERFLOW] = stampFifoCOverflow;
	end

	// Host strobe decodes used by the clear-on-read latches.
	always_comb begin
		readLatch = regHit(regRead, regAddr, OFS_LATCH);
		readStatus = regHit(regRead, regAddr, OFS_STATUS);
	end

	// All latched event bits clear together on a read of their register.
	pes_latch_bank #(
		.W(LATCH_W)
	) eventLatches (
		.mclk      (mclk),
		.rstSync_b (rstSync_b),
		.setPulse  (latchSet),
		.clearRead (readLatch),
		.latched   (latchedEvents)
	);

	// The overwrite error is the only latched bit of the live status register.
	pes_latch_bank #(
		.W(1)
	) overwriteLatch (
		.mclk      (mclk),
		.rstSync_b (rstSync_b),
		.setPulse  (multicastOverwriteError),
		.clearRead (readStatus),
		.latched   (overwriteLatched)
	);

	// Header fields follow packet transfers only.
	pes_header_capture headerCapture (
		.mclk               (mclk),
		.rstSync_b          (rstSync_b),
		.stampTransfer      (stampTransfer),
		.stampIsPacket      (stampIsPacket),
		.stampIsVersion2    (stampIsVersion2),
		.stampV1Control     (stampV1Control),
		.stampV2MessageType (stampV2MessageType),
		.stampIdentity      (stampIdentity),
		.headerInfo         (headerInfo)
	);

	// Enable register; reserved bits stay zero whatever the host writes.
	always_comb begin
		next_eventInterruptEnable = eventInterruptEnable;
		// Writes elsewhere are dropped here; the other registers have no writable bits.
		if (regHit(regWrite, regAddr, OFS_ENABLE)) begin
			next_eventInterruptEnable = regWdata & ENABLE_WRITE_MASK;
		end
	end

	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			eventInterruptEnable <= ENABLE_RESET;
		end else begin
			eventInterruptEnable <= next_eventInterruptEnable;
		end
	end

	// The summary is combinational on the latches so a read shows it in the same word.
	always_comb begin
		summary = |(latchedEvents & eventInterruptEnable[LATCH_W-1:0]);
	end

	always_comb begin
		latchWord = DATA_ZERO;
		latchWord[LATCH_W-1:0] = latchedEvents;
		latchWord[BIT_SUMMARY] = summary;
	end

	// Only the overwrite bit here is latched; the rest follow their sources live,
	// so two reads in a row may differ with no event in between.
	always_comb begin
		statusWord = DATA_ZERO;
		statusWord[SR_OVERWRITE_ERR] = overwriteLatched[0];
		statusWord[SR_GEN_A_FULL] = genAFifoFull;
		statusWord[SR_GEN_B_FULL] = genBFifoFull;
		statusWord[SR_FIFO_A_NONEMPTY] = stampFifoANonempty;
		statusWord[SR_FIFO_B_NONEMPTY] = stampFifoBNonempty;
		statusWord[SR_FIFO_C_NONEMPTY] = stampFifoCNonempty;
	end

	// Read data is captured on the read strobe so it stays still while shifted out.
	// The same edge clears the latches, so the word shows the events up to the
	// strobe and anything arriving with it waits for the next read.
	always_comb begin
		next_regRdata = regRdata;
		if (regRead) begin
			case (regAddr)
				OFS_LATCH: begin
					next_regRdata = latchWord;
				end
				OFS_ENABLE: begin
					next_regRdata = eventInterruptEnable;
				end
				OFS_STATUS: begin
					next_regRdata = statusWord;
				end
				OFS_HEADER: begin
					next_regRdata = headerInfo;
				end
				default: begin
					next_regRdata = DATA_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			regRdata <= DATA_ZERO;
		end else begin
			regRdata <= next_regRdata;
		end
	end

	// The interrupt output is registered so downstream logic never sees a glitch
	// while several latches and enables change in one cycle.
	always_comb begin
		next_eventInterrupt = summary;
	end

	always_ff @(posedge mclk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			eventInterrupt <= 1'b0;
		end else begin
			eventInterrupt <= next_eventInterrupt;
		end
	end

endmodule : pes_event_status_regs
`default_nettype wire

// File: test/pes_event_status_regs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module pes_event_status_regs_assertions
	import pes_pkg::*;
(
	input wire logic                 mclk,
	input wire logic                 rst_b,
	input wire logic [ADDR_W-1:0]    regAddr,
	input wire logic                 regRead,
	input wire logic                 regWrite,
	input wire logic [DATA_W-1:0]    regWdata,
	input wire logic [DATA_W-1:0]    regRdata,
	input wire logic                 timeAdjustDone,
	input wire logic                 genASequenceDone,
	input wire logic                 genAEventDone,
	input wire logic [CMD_W-1:0]     genAEventCommand,
	input wire logic                 genAFifoFull,
	input wire logic                 genBFifoFull,
	input wire logic                 stampFifoANonempty,
	input wire logic                 stampFifoAOverflow,
	input wire logic                 stampFifoBNonempty,
	input wire logic                 stampFifoCNonempty,
	input wire logic                 stampTransfer,
	input wire logic                 stampIsPacket,
	input wire logic                 stampIsVersion2,
	input wire logic [V1_CTRL_W-1:0] stampV1Control,
	input wire logic [MSG_W-1:0]     stampV2MessageType,
	input wire logic [ID_W-1:0]      stampIdentity
);
	wire logic       rdL = regRead && regAddr == OFS_LATCH;
	wire logic       rdS = regRead && regAddr == OFS_STATUS;
	wire logic       rdE = regRead && regAddr == OFS_ENABLE;
	wire logic       rdH = regRead && regAddr == OFS_HEADER;
	wire logic [3:0] v1Type = stampV1Control[3:0];
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	property p_seq; genASequenceDone ##1 !rdL ##1 rdL |=> regRdata[2]; endproperty
	a_seq: assert property (p_seq) else $error("sequence done lost");
	property p_evt; genAEventDone && genAEventCommand[21] ##1 !rdL ##1 rdL |=> regRdata[1]; endproperty
	a_evt: assert property (p_evt) else $error("marked event lost");
	property p_keep; timeAdjustDone && rdL ##1 !rdL ##1 rdL |=> regRdata[0]; endproperty
	a_keep: assert property (p_keep) else $error("event during read lost");
	property p_clr; rdL && !timeAdjustDone ##1 !timeAdjustDone ##1 rdL |=> !regRdata[0]; endproperty
	a_clr: assert property (p_clr) else $error("latch not cleared by read");
	property p_ovf; stampFifoAOverflow ##1 !rdL ##1 rdL |=> regRdata[9]; endproperty
	a_ovf: assert property (p_ovf) else $error("overflow lost");
	property p_ne; rdS |=> regRdata[9:7] == $past({stampFifoCNonempty, stampFifoBNonempty,
		stampFifoANonempty}); endproperty
	a_ne: assert property (p_ne) else $error("live not-empty wrong");
	property p_ff; rdS |=> {regRdata[6], regRdata[3]} == $past({genBFifoFull, genAFifoFull}); endproperty
	a_ff: assert property (p_ff) else $error("live full wrong");
	property p_rsv; rdS |=> regRdata[15:10] == 6'h00 && regRdata[5:4] == 2'h0 && regRdata[2:1] == 2'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved status bits set");
	property p_en; regWrite && regAddr == OFS_ENABLE ##1 !regWrite ##1 rdE && !regWrite
		|=> regRdata == ($past(regWdata, 3) & ENABLE_WRITE_MASK); endproperty
	a_en: assert property (p_en) else $error("enable readback wrong");
	property p_msg; stampTransfer && stampIsPacket ##1 !stampTransfer ##1 rdH |=> regRdata[15:12] ==
		($past(stampIsVersion2, 3) ? $past(stampV2MessageType, 3) : $past(v1Type, 3)); endproperty
	a_msg: assert property (p_msg) else $error("message type wrong");
	property p_id; stampTransfer && stampIsPacket ##1 !stampTransfer ##1 rdH
		|=> regRdata[11:0] == $past(stampIdentity, 3); endproperty
	a_id: assert property (p_id) else $error("identity wrong");
endmodule : pes_event_status_regs_assertions
bind pes_event_status_regs pes_event_status_regs_assertions u_chk (.*);
`default_nettype wire

// File: test/pes_event_status_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin badCount++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module pes_event_status_regs_tb_top;
	import pes_pkg::*;
	logic mclk = 1'b0, rst_b = 1'b0, regRead = 1'b0, regWrite = 1'b0, eventInterrupt;
	logic [ADDR_W-1:0] regAddr = 5'h00;
	logic [DATA_W-1:0] regWdata = 16'h0000, regRdata;
	logic timeAdjustDone = 1'b0, genASequenceDone = 1'b0, genAEventDone = 1'b0;
	logic genBSequenceDone = 1'b0, genBEventDone = 1'b0, genAFifoFull = 1'b0, genBFifoFull = 1'b0;
	logic [CMD_W-1:0] genAEventCommand = 22'h000000, genBEventCommand = 22'h000000;
	logic stampFifoANonempty = 1'b0, stampFifoBNonempty = 1'b0, stampFifoCNonempty = 1'b0;
	logic stampFifoAOverflow = 1'b0, stampFifoBOverflow = 1'b0, stampFifoCOverflow = 1'b0;
	logic multicastOverwriteError = 1'b0, stampTransfer = 1'b0, stampIsPacket = 1'b0;
	logic stampIsVersion2 = 1'b0;
	logic [V1_CTRL_W-1:0] stampV1Control = 8'h00;
	logic [MSG_W-1:0] stampV2MessageType = 4'h0;
	logic [ID_W-1:0] stampIdentity = 12'h000;
	int badCount = 0, totalChecks = 0, cycles = 0;
	pes_event_status_regs uut (.*);
	always #2 mclk = ~mclk;
	task automatic conclude();
		$display("checks %0d mismatches %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	// Reads leave an idle cycle after each transfer so strobes never repeat in one step.
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		`CHK(regRdata, e)
	endtask : rdc
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask : wr
	task automatic irq(input logic e);
		repeat (2) @(posedge mclk);
		#1;
		`CHK(eventInterrupt, e)
	endtask : irq
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			badCount++;
			conclude();
		end
	end
	initial begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (5) @(posedge mclk);
		rdc(OFS_LATCH, 16'h0000);
		rdc(OFS_ENABLE, ENABLE_RESET);
		rdc(OFS_STATUS, 16'h0000);
		rdc(OFS_HEADER, HEADER_RESET);
		rdc(5'h1f, DATA_ZERO);
		$display("test reset done");
		genAEventDone <= 1'b1;
		@(posedge mclk) genAEventDone <= 1'b0;
		rdc(OFS_LATCH, 16'h0000);
		{timeAdjustDone, genASequenceDone, genAEventDone, genBSequenceDone, genBEventDone} <= 5'h1f;
		{stampFifoAOverflow, stampFifoBOverflow, stampFifoCOverflow} <= 3'h7;
		genAEventCommand <= 22'h200000;
		genBEventCommand <= 22'h200000;
		@(posedge mclk);
		{timeAdjustDone, genASequenceDone, genAEventDone, genBSequenceDone, genBEventDone} <= 5'h00;
		{stampFifoAOverflow, stampFifoBOverflow, stampFifoCOverflow} <= 3'h0;
		rdc(OFS_LATCH, 16'h2a37);
		rdc(OFS_LATCH, 16'h0000);
		$display("test events done");
		{stampFifoANonempty, stampFifoBNonempty, stampFifoCNonempty} <= 3'h7;
		{genAFifoFull, genBFifoFull} <= 2'h3;
		rdc(OFS_STATUS, 16'h03c8);
		{genAFifoFull, genBFifoFull} <= 2'h0;
		multicastOverwriteError <= 1'b1;
		@(posedge mclk) multicastOverwriteError <= 1'b0;
		rdc(OFS_STATUS, 16'h0381);
		rdc(OFS_STATUS, 16'h0380);
		rdc(OFS_LATCH, 16'h1548);
		$display("test live status done");
		wr(OFS_ENABLE, 16'hffff);
		rdc(OFS_ENABLE, 16'h3f7f);
		irq(1'b0);
		wr(OFS_ENABLE, 16'h0001);
		timeAdjustDone <= 1'b1;
		@(posedge mclk) timeAdjustDone <= 1'b0;
		irq(1'b1);
		rdc(OFS_LATCH, 16'h4001);
		irq(1'b0);
		genASequenceDone <= 1'b1;
		@(posedge mclk) genASequenceDone <= 1'b0;
		irq(1'b0);
		@(posedge mclk);
		regAddr <= OFS_LATCH;
		regRead <= 1'b1;
		timeAdjustDone <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		timeAdjustDone <= 1'b0;
		#1;
		`CHK(regRdata, 16'h0004)
		rdc(OFS_LATCH, 16'h4001);
		wr(OFS_LATCH, 16'hffff);
		rdc(OFS_LATCH, 16'h0000);
		$display("test enable done");
		{stampTransfer, stampIsPacket, stampIsVersion2} <= 3'h6;
		{stampV1Control, stampV2MessageType, stampIdentity} <= {8'ha5, 4'h3, 12'h123};
		@(posedge mclk);
		{stampIsVersion2, stampV1Control, stampV2MessageType} <= {1'b1, 8'h07, 4'hc};
		stampIdentity <= 12'hfff;
		@(posedge mclk) stampTransfer <= 1'b0;
		rdc(OFS_HEADER, 16'hcfff);
		{stampTransfer, stampIsPacket, stampIdentity} <= {2'h2, 12'h000};
		@(posedge mclk) stampTransfer <= 1'b0;
		rdc(OFS_HEADER, 16'hcfff);
		{stampTransfer, stampIsPacket, stampIsVersion2} <= 3'h6;
		@(posedge mclk) stampTransfer <= 1'b0;
		wr(OFS_HEADER, 16'h1234);
		rdc(OFS_HEADER, 16'h7000);
		$display("test header done");
		conclude();
	end
endmodule : pes_event_status_regs_tb_top
`default_nettype wire
